// [pcr_defines.vh]
// Register map, field positions and reset values of the pad control register bank.
`ifndef PCR_DEFINES_VH
`define PCR_DEFINES_VH

// Byte address layout of the register port.
`define PCR_ADDR_W 9
`define PCR_BANK_BIT 8
`define PCR_IDX_HI 7
`define PCR_IDX_LO 2

// Register offsets within a bank.
`define PCR_VSEL_OFS 8'h00
`define PCR_USER_PAD0_OFS 8'h04
`define PCR_USER_PAD29_OFS 8'h78
`define PCR_DBG_CLK_OFS 8'h7c
`define PCR_DBG_DATA_OFS 8'h80
`define PCR_FLASH_CLK_OFS 8'h04
`define PCR_FLASH_SEL_OFS 8'h18

// Pad counts.
`define PCR_USER_PADS 32
`define PCR_FLASH_PADS 6

// Field positions within a pad register and the voltage select register.
`define PCR_OUT_DIS_BIT 7
`define PCR_IN_EN_BIT 6
`define PCR_DRV_HI 5
`define PCR_DRV_LO 4
`define PCR_PU_BIT 3
`define PCR_PD_BIT 2
`define PCR_HYS_BIT 1
`define PCR_FAST_BIT 0
`define PCR_VSEL_BIT 0

// Reset values.
`define PCR_VSEL_RST 1'h0
`define PCR_GEN_PAD_RST 8'h56
`define PCR_DBG_CLK_RST 8'hda
`define PCR_DBG_DATA_RST 8'h5a
`define PCR_FLASH_CLK_RST 8'h56
`define PCR_FLASH_DATA_RST 8'h52
`define PCR_FLASH_SEL_RST 8'h5a

`endif

// [pcr_pad_bank.v]
// Pad control register bank for the user and flash-interface pad banks.
//
// How it works
// - Per-bank voltage select bit 0, reset 0.
// - Bit 7 blocks peripheral output enable.
// - Bit 6 is read-write pad input enable.
// - Bits 5:4 drive strength code to pad.
// - Bit 3 pull-up, bit 2 pull-down.
// - Bit 1 read-write hysteresis enable.
// - Bit 0 selects fast or slow slew.
// - Upper register bits reserved, no function.
// - User map: select, pads, debug clock, data.
// - Flash map: select, clock, data, select pad.
// - Debug clock pad register reset value.
// - Flash data pad register reset value.
// - General user pads reset pulled low.
`timescale 1ns/1ps
`default_nettype none
`include "pcr_defines.vh"

module pcr_pad_bank #(
    parameter USER_PADS = `PCR_USER_PADS,
    parameter FLASH_PADS = `PCR_FLASH_PADS
) (
    // Clock and reset
    input wire mclk_i,
    input wire sys_rst_i,
    // Register port
    input wire [`PCR_ADDR_W-1:0] addr_i,
    input wire [31:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output wire [31:0] rdata_o,
    // Peripheral output enables
    input wire [USER_PADS-1:0] user_periph_oe_i,
    input wire [FLASH_PADS-1:0] flash_periph_oe_i,
    // User bank pad controls
    output wire user_io_supply_sel_o,
    output wire [USER_PADS-1:0] user_pad_oe_o,
    output wire [USER_PADS-1:0] user_pad_input_enable_o,
    output wire [2*USER_PADS-1:0] user_drive_o,
    output wire [USER_PADS-1:0] user_pull_up_enable_o,
    output wire [USER_PADS-1:0] user_pull_down_enable_o,
    output wire [USER_PADS-1:0] user_hysteresis_o,
    output wire [USER_PADS-1:0] user_fast_edge_select_o,
    // Flash bank pad controls
    output wire flash_io_supply_sel_o,
    output wire [FLASH_PADS-1:0] flash_pad_oe_o,
    output wire [FLASH_PADS-1:0] flash_pad_input_enable_o,
    output wire [2*FLASH_PADS-1:0] flash_drive_o,
    output wire [FLASH_PADS-1:0] flash_pull_up_enable_o,
    output wire [FLASH_PADS-1:0] flash_pull_down_enable_o,
    output wire [FLASH_PADS-1:0] flash_hysteresis_o,
    output wire [FLASH_PADS-1:0] flash_fast_edge_select_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Storage and decode.

    reg user_vsel_q;
    reg flash_vsel_q;
    reg [31:0] rdata_q;
    reg [31:0] rdata_d;

    // Stored pad bytes, pad n at [8n+7:8n], so the read path can index them.
    wire [8*USER_PADS-1:0] user_ctrl;
    wire [8*FLASH_PADS-1:0] flash_ctrl;
    wire [USER_PADS-1:0] user_we;
    wire [FLASH_PADS-1:0] flash_we;

    wire user_vsel_wr;
    wire user_pad_wr;
    wire user_vsel_rd;
    wire user_pad_rd;
    wire [5:0] user_slot;

    wire flash_vsel_wr;
    wire flash_pad_wr;
    wire flash_vsel_rd;
    wire flash_pad_rd;
    wire [5:0] flash_slot;

    function [7:0] user_rst;
        input integer i;
        begin
            if (i == USER_PADS - 2)
                user_rst = `PCR_DBG_CLK_RST;
            else if (i == USER_PADS - 1)
                user_rst = `PCR_DBG_DATA_RST;
            else
                user_rst = `PCR_GEN_PAD_RST;
        end
    endfunction

    function [7:0] flash_rst;
        input integer i;
        begin
            if (i == 0)
                flash_rst = `PCR_FLASH_CLK_RST;
            else if (i == FLASH_PADS - 1)
                flash_rst = `PCR_FLASH_SEL_RST;
            else
                flash_rst = `PCR_FLASH_DATA_RST;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Address decode, one copy per bank.

    pcr_bank_decode #(
        .FIRST_OFS(`PCR_USER_PAD0_OFS),
        .LAST_OFS(`PCR_DBG_DATA_OFS),
        .BANK_SEL(1'b0)
    ) pcr_bank_decode_user_i (
        .addr_i(addr_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .vsel_wr_o(user_vsel_wr),
        .pad_wr_o(user_pad_wr),
        .vsel_rd_o(user_vsel_rd),
        .pad_rd_o(user_pad_rd),
        .slot_o(user_slot)
    );

    pcr_bank_decode #(
        .FIRST_OFS(`PCR_FLASH_CLK_OFS),
        .LAST_OFS(`PCR_FLASH_SEL_OFS),
        .BANK_SEL(1'b1)
    ) pcr_bank_decode_flash_i (
        .addr_i(addr_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .vsel_wr_o(flash_vsel_wr),
        .pad_wr_o(flash_pad_wr),
        .vsel_rd_o(flash_vsel_rd),
        .pad_rd_o(flash_pad_rd),
        .slot_o(flash_slot)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Voltage select bits. Only bit 0 is stored, so reserved bits drop.

    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            user_vsel_q <= `PCR_VSEL_RST;
            flash_vsel_q <= `PCR_VSEL_RST;
        end else begin
            if (user_vsel_wr)
                user_vsel_q <= wdata_i[`PCR_VSEL_BIT];
            if (flash_vsel_wr)
                flash_vsel_q <= wdata_i[`PCR_VSEL_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path: data stand in the cycle after the strobe, zero elsewhere.

    always @* begin
        rdata_d = 32'h0000_0000;
        if (user_vsel_rd)
            rdata_d = {31'h0000_0000, user_vsel_q};
        else if (flash_vsel_rd)
            rdata_d = {31'h0000_0000, flash_vsel_q};
        else if (user_pad_rd)
            rdata_d = {24'h00_0000, user_ctrl[{user_slot[4:0], 3'b000} +: 8]};
        else if (flash_pad_rd)
            rdata_d = {24'h00_0000, flash_ctrl[{flash_slot[2:0], 3'b000} +: 8]};
    end

    always @(posedge mclk_i) begin
        if (sys_rst_i)
            rdata_q <= 32'h0000_0000;
        else
            rdata_q <= rdata_d;
    end

    assign rdata_o = rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // Static pad control lines, straight from the stored fields.

    assign user_io_supply_sel_o = user_vsel_q;
    assign flash_io_supply_sel_o = flash_vsel_q;

    ////////////////////////////////////////////////////////////////////////////
    // One pad register per pad, each with its own write enable.

    genvar g;
    generate
        for (g = 0; g < USER_PADS; g = g + 1) begin : g_user
            assign user_we[g] = user_pad_wr && (user_slot == g);
            pcr_pad_reg #(
                .RST_VAL(user_rst(g))
            ) pcr_pad_reg_i (
                .mclk_i(mclk_i),
                .sys_rst_i(sys_rst_i),
                .we_i(user_we[g]),
                .wdata_i(wdata_i[7:0]),
                .periph_oe_i(user_periph_oe_i[g]),
                .ctrl_o(user_ctrl[8*g+7:8*g]),
                .pad_oe_o(user_pad_oe_o[g]),
                .input_enable_o(user_pad_input_enable_o[g]),
                .drive_o(user_drive_o[2*g+1:2*g]),
                .pull_up_enable_o(user_pull_up_enable_o[g]),
                .pull_down_enable_o(user_pull_down_enable_o[g]),
                .hysteresis_o(user_hysteresis_o[g]),
                .fast_edge_select_o(user_fast_edge_select_o[g])
            );
        end
        for (g = 0; g < FLASH_PADS; g = g + 1) begin : g_flash
            assign flash_we[g] = flash_pad_wr && (flash_slot == g);
            pcr_pad_reg #(
                .RST_VAL(flash_rst(g))
            ) pcr_pad_reg_i (
                .mclk_i(mclk_i),
                .sys_rst_i(sys_rst_i),
                .we_i(flash_we[g]),
                .wdata_i(wdata_i[7:0]),
                .periph_oe_i(flash_periph_oe_i[g]),
                .ctrl_o(flash_ctrl[8*g+7:8*g]),
                .pad_oe_o(flash_pad_oe_o[g]),
                .input_enable_o(flash_pad_input_enable_o[g]),
                .drive_o(flash_drive_o[2*g+1:2*g]),
                .pull_up_enable_o(flash_pull_up_enable_o[g]),
                .pull_down_enable_o(flash_pull_down_enable_o[g]),
                .hysteresis_o(flash_hysteresis_o[g]),
                .fast_edge_select_o(flash_fast_edge_select_o[g])
            );
        end
    endgenerate

endmodule // pcr_pad_bank

////////////////////////////////////////////////////////////////////////////////
// Address decode for one bank: voltage select word and a window of pad words.

module pcr_bank_decode #(
    parameter [7:0] FIRST_OFS = 8'h04,
    parameter [7:0] LAST_OFS = 8'h04,
    parameter [0:0] BANK_SEL = 1'b0
) (
    // Register port
    input wire [`PCR_ADDR_W-1:0] addr_i,
    input wire wr_i,
    input wire rd_i,
    // Decoded selects
    output wire vsel_wr_o,
    output wire pad_wr_o,
    output wire vsel_rd_o,
    output wire pad_rd_o,
    output wire [5:0] slot_o
);

    wire [7:0] ofs = {addr_i[`PCR_IDX_HI:`PCR_IDX_LO], 2'b00};
    // A misaligned address matches nothing, so it neither writes nor reads.
    wire in_bank = (addr_i[`PCR_BANK_BIT] == BANK_SEL) && (addr_i[1:0] == 2'b00);
    wire is_vsel = (ofs == `PCR_VSEL_OFS);
    wire is_pad = (ofs >= FIRST_OFS) && (ofs <= LAST_OFS);

    assign vsel_wr_o = wr_i && in_bank && is_vsel;
    assign pad_wr_o = wr_i && in_bank && is_pad;
    assign vsel_rd_o = rd_i && in_bank && is_vsel;
    assign pad_rd_o = rd_i && in_bank && is_pad;

    // Pad slot is the word index less one; only meaningful while a pad is hit.
    assign slot_o = addr_i[`PCR_IDX_HI:`PCR_IDX_LO] - 6'h01;

endmodule // pcr_bank_decode

////////////////////////////////////////////////////////////////////////////////
// One pad control register with its output enable gate.

module pcr_pad_reg #(
    parameter [7:0] RST_VAL = 8'h00
) (
    // Clock and reset
    input wire mclk_i,
    input wire sys_rst_i,
    // Register write
    input wire we_i,
    input wire [7:0] wdata_i,
    // Peripheral output enable
    input wire periph_oe_i,
    // Stored byte for read back
    output wire [7:0] ctrl_o,
    // Pad cell controls
    output wire pad_oe_o,
    output wire input_enable_o,
    output wire [1:0] drive_o,
    output wire pull_up_enable_o,
    output wire pull_down_enable_o,
    output wire hysteresis_o,
    output wire fast_edge_select_o
);

    reg [7:0] ctrl_q;
    reg oe_q;

    // Only the eight defined bits have flops, so reserved bits cannot hold a value.
    always @(posedge mclk_i) begin
        if (sys_rst_i)
            ctrl_q <= RST_VAL;
        else if (we_i)
            ctrl_q <= wdata_i;
    end

    // The enable is registered so the pad sees a flop; the cost is that a
    // peripheral request reaches the pad one cycle late.
    always @(posedge mclk_i) begin
        if (sys_rst_i)
            oe_q <= 1'b0;
        else
            oe_q <= periph_oe_i & ~ctrl_q[`PCR_OUT_DIS_BIT];
    end

    assign ctrl_o = ctrl_q;
    assign pad_oe_o = oe_q;
    assign input_enable_o = ctrl_q[`PCR_IN_EN_BIT];
    assign drive_o = ctrl_q[`PCR_DRV_HI:`PCR_DRV_LO];
    assign pull_up_enable_o = ctrl_q[`PCR_PU_BIT];
    assign pull_down_enable_o = ctrl_q[`PCR_PD_BIT];
    assign hysteresis_o = ctrl_q[`PCR_HYS_BIT];
    assign fast_edge_select_o = ctrl_q[`PCR_FAST_BIT];

endmodule // pcr_pad_reg
`default_nettype wire

// [pcr_pad_bank_assertions.sv]
// Concurrent checks on the ports of the pad control register bank.
`timescale 1ns/1ps
`default_nettype none
module pcr_pad_bank_chk #(
    parameter USER_PADS = 32,
    parameter FLASH_PADS = 6
) (
    input wire logic mclk_i, sys_rst_i, wr_i, rd_i, flash_io_supply_sel_o,
    input wire logic [8:0] addr_i,
    input wire logic [31:0] wdata_i, rdata_o,
    input wire logic [USER_PADS-1:0] user_periph_oe_i, user_pad_oe_o, user_pad_input_enable_o,
    input wire logic [USER_PADS-1:0] user_hysteresis_o, user_pull_up_enable_o,
    input wire logic [2*USER_PADS-1:0] user_drive_o,
    input wire logic [FLASH_PADS-1:0] flash_pull_up_enable_o, flash_pull_down_enable_o, flash_fast_edge_select_o
);
default clocking @(posedge mclk_i); endclocking
default disable iff (sys_rst_i);
chk_rd_idle_zero: assert property (!$past(rd_i) |-> rdata_o == 32'h0000_0000)
    else $error("read data not zero outside a read answer");
chk_oe_gated: assert property ((user_pad_oe_o & ~$past(user_periph_oe_i)) == 32'h0000_0000)
    else $error("pad output enable without peripheral enable");
chk_wr_drive: assert property (wr_i && addr_i == 9'h078 |=> user_drive_o[59:58] == $past(wdata_i[5:4]))
    else $error("drive code not taken from write");
chk_wr_pulls: assert property (wr_i && addr_i == 9'h104 |=>
    flash_pull_up_enable_o[0] == $past(wdata_i[3]) && flash_pull_down_enable_o[0] == $past(wdata_i[2]))
    else $error("pull enables not taken from write");
chk_wr_vsel: assert property (wr_i && addr_i == 9'h100 |=> flash_io_supply_sel_o == $past(wdata_i[0]))
    else $error("voltage select not taken from write");
chk_wr_ie_hys: assert property (wr_i && addr_i == 9'h07c |=>
    user_pad_input_enable_o[30] == $past(wdata_i[6]) && user_hysteresis_o[30] == $past(wdata_i[1]))
    else $error("input enable or hysteresis not taken from write");
chk_wr_slew: assert property (wr_i && addr_i == 9'h118 |=> flash_fast_edge_select_o[5] == $past(wdata_i[0]))
    else $error("slew select not taken from write");
chk_ctrl_hold: assert property (!wr_i && !sys_rst_i |=> $stable(user_drive_o))
    else $error("drive code changed without a write");
// Reset itself is the cause here, so this one is not disabled by it.
chk_rst_dbg_clk: assert property (disable iff (1'b0) sys_rst_i |=>
    user_drive_o[61:60] == 2'h1 && user_pull_up_enable_o[30])
    else $error("debug clock pad reset value wrong");
endmodule // pcr_pad_bank_chk
bind pcr_pad_bank pcr_pad_bank_chk #(.USER_PADS(USER_PADS), .FLASH_PADS(FLASH_PADS)) pcr_pad_bank_chk_i (
    .mclk_i, .sys_rst_i, .wr_i, .rd_i, .flash_io_supply_sel_o, .addr_i, .wdata_i, .rdata_o,
    .user_periph_oe_i, .user_pad_oe_o, .user_pad_input_enable_o, .user_hysteresis_o,
    .user_pull_up_enable_o, .user_drive_o, .flash_pull_up_enable_o, .flash_pull_down_enable_o,
    .flash_fast_edge_select_o);
`default_nettype wire

// [pcr_periph_model.sv]
// Peripheral side model driving output enables toward the pad bank.
`timescale 1ns/1ps
`default_nettype none
module pcr_periph_model (
    input wire logic mclk_i,
    input wire logic en_i,
    output logic [31:0] user_oe_o = 32'h0000_0000,
    output logic [5:0] flash_oe_o = 6'h00
);
// Enables change just after an edge, as a peripheral flop would.
always @(posedge mclk_i) begin
    user_oe_o <= {32{en_i}};
    flash_oe_o <= {6{en_i}};
end
endmodule // pcr_periph_model
`default_nettype wire

// [pad_control_register_bank_bench.sv]
// Self-checking bench of the pad control register bank.
`timescale 1ns/1ps
`default_nettype none
module pad_control_register_bank_bench;
logic mclk_i = 1'b0, sys_rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, oe_en = 1'b1;
logic [8:0] addr_i = 9'h000;
logic [31:0] wdata_i = 32'h0000_0000;
wire [31:0] user_periph_oe_i, rdata_o, user_pad_oe_o, user_pad_input_enable_o, user_pull_up_enable_o;
wire [31:0] user_pull_down_enable_o, user_hysteresis_o, user_fast_edge_select_o;
wire [63:0] user_drive_o;
wire [11:0] flash_drive_o;
wire [5:0] flash_periph_oe_i, flash_pad_oe_o, flash_pad_input_enable_o, flash_pull_up_enable_o;
wire [5:0] flash_pull_down_enable_o, flash_hysteresis_o, flash_fast_edge_select_o;
wire user_io_supply_sel_o, flash_io_supply_sel_o;
int fail_count = 0, cmp_count = 0, cyc = 0;
logic [72:0] rows [10];
always #10 mclk_i = ~mclk_i;
pcr_pad_bank pcr_pad_bank_i (.mclk_i, .sys_rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .user_periph_oe_i, .flash_periph_oe_i, .user_io_supply_sel_o, .user_pad_oe_o, .user_pad_input_enable_o,
    .user_drive_o, .user_pull_up_enable_o, .user_pull_down_enable_o, .user_hysteresis_o,
    .user_fast_edge_select_o, .flash_io_supply_sel_o, .flash_pad_oe_o, .flash_pad_input_enable_o,
    .flash_drive_o, .flash_pull_up_enable_o, .flash_pull_down_enable_o, .flash_hysteresis_o,
    .flash_fast_edge_select_o);
pcr_periph_model pcr_periph_model_i (.mclk_i, .en_i(oe_en), .user_oe_o(user_periph_oe_i),
    .flash_oe_o(flash_periph_oe_i));
task check(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
        $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        fail_count++;
    end
endtask
task wr(input logic [8:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
endtask
// Read data stand only in the cycle after the strobe, so sample just past that edge.
task rd_chk(input logic [8:0] a, input logic [31:0] e);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 check(rdata_o, e);
endtask
task complete_run;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
        $display("Run complete: PASS");
    else
        $display("Run complete: FAIL");
    $finish;
endtask
always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 1000) begin
        fail_count++;
        complete_run;
    end
end
initial begin
    rows = '{{9'h000, 32'hffff_ffff, 32'h0000_0001}, {9'h004, 32'hffff_ff80, 32'h0000_0080},
        {9'h078, 32'h0000_0155, 32'h0000_0055}, {9'h07c, 32'h0000_0042, 32'h0000_0042},
        {9'h080, 32'h0000_00aa, 32'h0000_00aa}, {9'h100, 32'h0000_0003, 32'h0000_0001},
        {9'h104, 32'h0000_003c, 32'h0000_003c}, {9'h118, 32'h0000_00c3, 32'h0000_00c3},
        {9'h11c, 32'h0000_00ff, 32'h0000_0000}, {9'h086, 32'h0000_00ff, 32'h0000_0000}};
    repeat (6) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    foreach (rows[i]) begin
        wr(rows[i][72:64], rows[i][63:32]);
        rd_chk(rows[i][72:64], rows[i][31:0]);
    end
    $display("table test done");
    @(posedge mclk_i);
    #1 check({user_pad_oe_o[1:0], user_io_supply_sel_o, user_drive_o[59:58], flash_pull_down_enable_o[0],
        flash_fast_edge_select_o[5], user_pad_input_enable_o[30]}, 32'h0000_00af);
    check({user_pull_down_enable_o[31], user_hysteresis_o[31], user_fast_edge_select_o[29], flash_drive_o[1:0],
        flash_pad_oe_o, flash_pad_input_enable_o[5], flash_pull_up_enable_o[0], flash_hysteresis_o[5],
        flash_io_supply_sel_o}, 32'h0000_3dff);
    @(posedge mclk_i);
    oe_en <= 1'b0;
    repeat (2) @(posedge mclk_i);
    #1 check(user_pad_oe_o, 32'h0000_0000);
    check({26'h000_0000, flash_pad_oe_o}, 32'h0000_0000);
    $display("pad output test done");
    @(posedge mclk_i);
    sys_rst_i <= 1'b1;
    @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    rd_chk(9'h07c, 32'h0000_00da);
    rd_chk(9'h108, 32'h0000_0052);
    rd_chk(9'h004, 32'h0000_0056);
    rd_chk(9'h100, 32'h0000_0000);
    $display("reset test done");
    complete_run;
end
endmodule // pad_control_register_bank_bench
`default_nettype wire
